// File: design/msd_pkg.sv
// package for the memory space decoder: address map, sizes and carriers
package msd_pkg;
  // ---------------------------------------------------------------
  // register file map
  // ---------------------------------------------------------------
  localparam logic [11:0] MSD_RF_RAM_BASE = 12'h000;
  localparam int MSD_RF_RAM_MAX = 256;
  localparam logic [11:0] MSD_RF_CTL_BASE = 12'hf00;
  localparam logic [11:0] MSD_RF_CTL_LAST = 12'hfff;
  localparam logic [7:0] MSD_RF_UNDEF_VAL = 8'h00;
  // ---------------------------------------------------------------
  // program memory map
  // ---------------------------------------------------------------
  localparam int MSD_FLASH_MIN = 1024;
  localparam int MSD_FLASH_MAX = 12288;
  localparam logic [15:0] MSD_PM_OPT_BASE = 16'h0000;
  localparam logic [15:0] MSD_PM_RST_VEC = 16'h0002;
  localparam logic [15:0] MSD_PM_IRQ_VEC = 16'h0004;
  localparam logic [15:0] MSD_PM_CODE_BASE = 16'h003e;
  localparam logic [7:0] MSD_PM_BLANK = 8'hff;
  localparam logic [15:0] MSD_INFO_BASE = 16'hfe00;
  localparam logic [15:0] MSD_INFO_LAST = 16'hfe7f;
  localparam logic [15:0] MSD_INFO_ID_BASE = 16'hfe40;
  localparam logic [15:0] MSD_INFO_ID_LAST = 16'hfe53;
  localparam int MSD_INFO_EN_BIT = 7;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MSD_SP_REG, MSD_SP_PROG, MSD_SP_DATA} msd_space_t;
  typedef struct packed {
    logic vld;
    logic wr;
    msd_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } msd_req_t;
  typedef struct packed {
    logic vld;
    logic [7:0] rdata;
  } msd_rsp_t;
endpackage

// File: design/msd_info_rom.sv
// read-only information area: 128 bytes with the part identifier
`timescale 1ns/100ps
module msd_info_rom
  import msd_pkg::*;
(
  input wire logic [6:0] addr,
  output logic [7:0] data
);
  // identifier text is arbitrary, space in the map is filler nibbles
  localparam logic [159:0] ID_TEXT = "MSD-PART-0001\xff\xff\xff\xff\xff\xff\xff";
  localparam logic [6:0] ID_OFS = 7'(MSD_INFO_ID_BASE - MSD_INFO_BASE);
  localparam logic [6:0] ID_END = 7'(MSD_INFO_ID_LAST - MSD_INFO_BASE);
  logic [7:0] rom [128];

  // ---------------------------------------------------------------
  // contents: identifier left-justified, all else erased
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 128; i++) begin : g_rom
      if (i >= ID_OFS && i <= ID_END) begin : g_id
        assign rom[i] = ID_TEXT[8*(19-(i-ID_OFS)) +: 8];
      end else begin : g_blank
        assign rom[i] = MSD_PM_BLANK;
      end
    end
  endgenerate

  // no write port exists, so the area can never change
  assign data = rom[addr];
endmodule

// File: design/msd_decoder.sv
// address space decoder: register file, program memory, data memory
`timescale 1ns/100ps
// Behaviour
// - decode 4 KB register file into RAM region and control region
// - addresses F00H to FFFH go to control registers, not RAM
// - unimplemented control addresses may read any value
// - RAM starts at 000H, at most 256 bytes
// - between RAM end and F00H reads undefined, writes ignored
// - program space spans 64 KB, flash at the bottom
// - flash size 1 KB to 12 KB sets the flash decode limit
// - program reads beyond flash return FFH
// - writes to unimplemented program addresses change nothing
// - option bits 0000-0001, reset vector 0002-0003, vectors to 003D, code from 003E
// - nothing is mapped in the data memory space
// - information area enabled only while page select bit 7 is set
// - enabled reads in FE00H to FE7FH return information area bytes
// - information area is read only
// - FE40-FE53 hold a 20-character ASCII identifier padded with F nibbles
module msd_decoder
  import msd_pkg::*;
#(
  parameter int RAM_BYTES = MSD_RF_RAM_MAX,
  parameter int FLASH_BYTES = 8192
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire msd_req_t cpu_req,
  output msd_rsp_t cpu_rsp,
  input wire logic [7:0] page_sel,
  output logic ctl_sel,
  output logic ctl_wr,
  output logic [7:0] ctl_addr,
  output logic [7:0] ctl_wdata,
  input wire logic [7:0] ctl_rdata,
  output logic flash_rd,
  output logic flash_wr,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  output logic [1:0] pm_region
);
  // ---------------------------------------------------------------
  // decode of the incoming request
  // ---------------------------------------------------------------
  localparam logic [15:0] FLASH_LAST = 16'(FLASH_BYTES - 1);
  localparam logic [11:0] RAM_LAST = 12'(RAM_BYTES - 1);

  logic [7:0] ram [RAM_BYTES];
  logic [11:0] rf_addr;
  logic is_reg, is_prog, hit_ram, hit_ctl, hit_flash, hit_info, info_en;
  logic [7:0] info_data;
  logic [1:0] src_d, src_q;
  logic rsp_vld_q;
  logic [7:0] ram_q, fixed_q;

  // register file only sees twelve address bits
  assign rf_addr = cpu_req.addr[11:0];
  assign is_reg = cpu_req.vld && cpu_req.space == MSD_SP_REG;
  assign is_prog = cpu_req.vld && cpu_req.space == MSD_SP_PROG;
  assign hit_ram = is_reg && rf_addr <= RAM_LAST && rf_addr < MSD_RF_CTL_BASE;
  assign hit_ctl = is_reg && rf_addr >= MSD_RF_CTL_BASE;
  assign info_en = page_sel[MSD_INFO_EN_BIT];
  assign hit_info = is_prog && info_en && cpu_req.addr >= MSD_INFO_BASE
                    && cpu_req.addr <= MSD_INFO_LAST;
  // overlay disabled falls through to the ordinary limit check
  assign hit_flash = is_prog && !hit_info && cpu_req.addr <= FLASH_LAST;

  // ---------------------------------------------------------------
  // downstream strobes, combinational handshakes
  // ---------------------------------------------------------------
  assign ctl_sel = hit_ctl;
  assign ctl_wr = hit_ctl && cpu_req.wr;
  assign ctl_addr = rf_addr[7:0];
  assign ctl_wdata = cpu_req.wdata;
  assign flash_rd = hit_flash && !cpu_req.wr;
  // writes outside flash or into the overlay never reach storage
  assign flash_wr = hit_flash && cpu_req.wr;
  assign flash_addr = cpu_req.addr;
  assign flash_wdata = cpu_req.wdata;

  // region classifier for the fetch unit
  always_comb begin
    if (cpu_req.addr < MSD_PM_RST_VEC) begin
      pm_region = 2'h0;
    end else if (cpu_req.addr < MSD_PM_IRQ_VEC) begin
      pm_region = 2'h1;
    end else if (cpu_req.addr < MSD_PM_CODE_BASE) begin
      pm_region = 2'h2;
    end else begin
      pm_region = 2'h3;
    end
  end

  msd_info_rom u_msd_info_rom (
    .addr(cpu_req.addr[6:0]),
    .data(info_data)
  );

  // ---------------------------------------------------------------
  // on-chip RAM
  // ---------------------------------------------------------------
  // writes above the RAM limit are simply dropped
  always_ff @(posedge clk_sys) begin
    if (hit_ram && cpu_req.wr) begin
      ram[rf_addr[7:0]] <= cpu_req.wdata;
    end
    ram_q <= ram[rf_addr[7:0]];
  end

  // ---------------------------------------------------------------
  // read data source select, one cycle latency
  // ---------------------------------------------------------------
  always_comb begin
    if (hit_ram) begin
      src_d = 2'h1;
    end else if (hit_ctl) begin
      src_d = 2'h2;
    end else if (hit_flash) begin
      src_d = 2'h3;
    end else begin
      src_d = 2'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_q <= 2'h0;
      rsp_vld_q <= 1'b0;
      fixed_q <= 8'h00;
    end else begin
      src_q <= src_d;
      rsp_vld_q <= cpu_req.vld && !cpu_req.wr;
      if (hit_info) begin
        fixed_q <= info_data;
      end else if (is_prog) begin
        fixed_q <= MSD_PM_BLANK;
      end else begin
        fixed_q <= MSD_RF_UNDEF_VAL;
      end
    end
  end

  // control window answers with whatever the peripheral drives
  always_comb begin
    cpu_rsp.vld = rsp_vld_q;
    unique case (src_q)
      2'h1: cpu_rsp.rdata = ram_q;
      2'h2: cpu_rsp.rdata = ctl_rdata;
      2'h3: cpu_rsp.rdata = flash_rdata;
      default: cpu_rsp.rdata = fixed_q;
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  blank_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_prog && !cpu_req.wr && !hit_info && cpu_req.addr > FLASH_LAST
    |=> cpu_rsp.vld && cpu_rsp.rdata == MSD_PM_BLANK)
    else $error("read beyond flash did not return ff");
  info_overlay_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hit_info |-> !flash_rd && !flash_wr)
    else $error("overlay read reached flash");
  info_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hit_info |-> page_sel[7])
    else $error("overlay active with enable clear");
  overlay_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_prog && !page_sel[7] && cpu_req.addr <= FLASH_LAST |-> hit_flash)
    else $error("disabled overlay did not decode normally");
  ctl_window_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_reg && cpu_req.addr[11:8] == 4'hf |-> ctl_sel && !hit_ram)
    else $error("control window not routed");
  ram_base_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_reg && cpu_req.addr[11:8] == 4'h0 |-> hit_ram)
    else $error("ram base not decoded");
  prog_wr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flash_wr |-> cpu_req.addr <= FLASH_LAST && !hit_info)
    else $error("write passed to unimplemented program address");
  data_space_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_req.vld && cpu_req.space == MSD_SP_DATA
    |-> !ctl_sel && !flash_rd && !flash_wr)
    else $error("data space access reached a resource");
  gap_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_reg && !cpu_req.wr && !hit_ram && !hit_ctl |=> cpu_rsp.vld)
    else $error("gap read not answered");

  // ---------------------------------------------------------------
  // answer checks, one cycle after the request
  // ---------------------------------------------------------------
  // a read answers exactly once; a write or an idle cycle never does
  read_answer_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_req.vld && !cpu_req.wr |=> cpu_rsp.vld)
    else $error("read not answered");
  write_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_req.vld && cpu_req.wr |=> !cpu_rsp.vld)
    else $error("write produced an answer");
  rsp_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cpu_req.vld |=> !cpu_rsp.vld)
    else $error("answer without a request");
  // data must come from the source that the decode picked
  flash_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hit_flash && !cpu_req.wr |=> cpu_rsp.rdata == flash_rdata)
    else $error("flash read data not passed");
  ctl_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hit_ctl && !cpu_req.wr |=> cpu_rsp.rdata == ctl_rdata)
    else $error("control read data not passed");
  info_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hit_info && !cpu_req.wr |=> cpu_rsp.rdata == $past(info_data))
    else $error("overlay read data not passed");
  // gap and data space reads share the fill value, never stale data
  gap_data_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_req.vld && !cpu_req.wr && !is_prog && !hit_ram && !hit_ctl
    |=> cpu_rsp.rdata == MSD_RF_UNDEF_VAL)
    else $error("unmapped read data not the fill value");

  // ---------------------------------------------------------------
  // decode structure checks
  // ---------------------------------------------------------------
  // register accesses must never leak onto the flash strobes
  reg_space_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_reg |-> !flash_rd && !flash_wr)
    else $error("register access reached flash");
  code_region_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_prog && cpu_req.addr >= MSD_PM_CODE_BASE |-> pm_region == 2'h3)
    else $error("code area not classified");
  // a variant outside the legal flash sizes is a build mistake
  flash_size_a: assert property (@(posedge clk_sys)
    FLASH_BYTES >= MSD_FLASH_MIN && FLASH_BYTES <= MSD_FLASH_MAX)
    else $error("flash size outside the legal range");
endmodule

// File: tb/msd_far_model.sv
// far-side model: flash array and control registers answering the decoder
`timescale 1ns/100ps
module msd_far_model
  import msd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic ctl_sel,
  input wire logic [7:0] ctl_addr,
  output logic [7:0] ctl_rdata,
  input wire logic flash_rd,
  input wire logic [15:0] flash_addr,
  output logic [7:0] flash_rdata
);
  // ---------------------------------------------------------------
  // responders
  // ---------------------------------------------------------------
  // data follows the address so a wrong decode shows; idle cycles flip
  // the bus so a stale value never passes for an answer
  initial ctl_rdata = 8'h00;
  initial flash_rdata = 8'h00;
  always @(posedge clk_sys) begin
    ctl_rdata <= ctl_sel ? (ctl_addr ^ 8'ha5) : ~ctl_rdata;
  end
  always @(posedge clk_sys) begin
    flash_rdata <= flash_rd ? (flash_addr[7:0] ^ 8'h5a) : ~flash_rdata;
  end
endmodule

// File: tb/memory_space_decoder_test.sv
// self-checking testbench for the memory space decoder
`timescale 1ns/100ps
module memory_space_decoder_test
  import msd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  msd_req_t cpu_req;
  msd_rsp_t cpu_rsp;
  logic [7:0] page_sel, ctl_addr, ctl_wdata, ctl_rdata, flash_wdata, flash_rdata, rd;
  logic ctl_sel, ctl_wr, flash_rd, flash_wr, rv;
  logic [15:0] flash_addr;
  logic [1:0] pm_region;
  logic [5:0] snap;
  int err_count = 0;
  int n_tests = 0;
  // ---------------------------------------------------------------
  // harness
  // ---------------------------------------------------------------
  always #2.5 clk_sys = ~clk_sys;
  msd_decoder #(.RAM_BYTES(256), .FLASH_BYTES(8192)) u_msd_decoder (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .page_sel(page_sel),
    .ctl_sel(ctl_sel), .ctl_wr(ctl_wr), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata), .flash_rd(flash_rd), .flash_wr(flash_wr),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
    .pm_region(pm_region));
  msd_far_model u_msd_far_model (.clk_sys(clk_sys), .ctl_sel(ctl_sel),
    .ctl_addr(ctl_addr), .ctl_rdata(ctl_rdata), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata));
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask
  // one request cycle; strobes sampled in it, answer one cycle later
  task automatic acc(input logic w, input msd_space_t sp, input logic [15:0] a,
                     input logic [7:0] wd);
    @(posedge clk_sys);
    cpu_req <= '{vld: 1'b1, wr: w, space: sp, addr: a, wdata: wd};
    #1;
    snap = {ctl_sel, ctl_wr, flash_rd, flash_wr, pm_region};
    @(posedge clk_sys);
    cpu_req.vld <= 1'b0;
    #1;
    rv = cpu_rsp.vld;
    rd = cpu_rsp.rdata;
  endtask
  task automatic rdck(input msd_space_t sp, input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, sp, a, 8'h00);
    chk("rsp_vld", 16'h0001, {15'h0, rv});
    chk("rdata", {8'h00, e}, {8'h00, rd});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_ram();
    acc(1'b1, MSD_SP_REG, 16'h0000, 8'h3c);
    chk("wr_rsp_vld", 16'h0000, {15'h0, rv});
    acc(1'b1, MSD_SP_REG, 16'h00ff, 8'hc3);
    rdck(MSD_SP_REG, 16'h00ff, 8'hc3);
    chk("ram_ctl_sel", 16'h0000, {15'h0, snap[5]});
    acc(1'b1, MSD_SP_REG, 16'h0100, 8'h77);
    rdck(MSD_SP_REG, 16'h0100, 8'h00);
    rdck(MSD_SP_REG, 16'h0000, 8'h3c);
  endtask
  task automatic t_ctl();
    rdck(MSD_SP_REG, 16'h0f00, 8'h00 ^ 8'ha5);
    chk("ctl_sel", 16'h0001, {15'h0, snap[5]});
    rdck(MSD_SP_REG, 16'h0fff, 8'hff ^ 8'ha5);
    rdck(MSD_SP_REG, 16'h0f71, 8'h71 ^ 8'ha5);
    acc(1'b1, MSD_SP_REG, 16'h0f00, 8'h12);
    chk("ctl_wr", 16'h0001, {15'h0, snap[4]});
    chk("ctl_wdata", 16'h0012, {8'h00, ctl_wdata});
  endtask
  task automatic t_pm();
    logic [15:0] a [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h003d,
                           16'h003e};
    logic [1:0] r [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    for (int i = 0; i < 7; i++) begin
      rdck(MSD_SP_PROG, a[i], a[i][7:0] ^ 8'h5a);
      chk("pm_region", {14'h0, r[i]}, {14'h0, snap[1:0]});
    end
    rdck(MSD_SP_PROG, 16'h1fff, 8'hff ^ 8'h5a);
    rdck(MSD_SP_PROG, 16'h2000, 8'hff);
    acc(1'b1, MSD_SP_PROG, 16'h2000, 8'h00);
    chk("flash_wr", 16'h0000, {15'h0, snap[2]});
    acc(1'b1, MSD_SP_PROG, 16'h0100, 8'h9a);
    chk("flash_wr_in", 16'h0001, {15'h0, snap[2]});
    chk("flash_wdata", 16'h009a, {8'h00, flash_wdata});
    chk("flash_addr", 16'h0100, flash_addr);
  endtask
  task automatic t_info();
    logic [103:0] id = "MSD-PART-0001";
    @(posedge clk_sys);
    page_sel <= 8'h80;
    for (int i = 0; i < 20; i++) begin
      rdck(MSD_SP_PROG, 16'hfe40 + 16'(i), (i < 13) ? id[8*(12-i) +: 8] : 8'hff);
    end
    rdck(MSD_SP_PROG, 16'hfe00, 8'hff);
    rdck(MSD_SP_PROG, 16'hfe7f, 8'hff);
    acc(1'b1, MSD_SP_PROG, 16'hfe40, 8'h00);
    chk("info_wr", 16'h0000, {15'h0, snap[2]});
    rdck(MSD_SP_PROG, 16'hfe40, 8'h4d);
    @(posedge clk_sys);
    page_sel <= 8'h7f;
    rdck(MSD_SP_PROG, 16'hfe40, 8'hff);
  endtask
  task automatic t_data();
    rdck(MSD_SP_DATA, 16'h0010, 8'h00);
    acc(1'b1, MSD_SP_DATA, 16'h0000, 8'h55);
    chk("data_wr", 16'h0000, {14'h0, snap[4], snap[2]});
    rdck(MSD_SP_REG, 16'h0000, 8'h3c);
  endtask
  initial begin
    cpu_req = '0;
    page_sel = 8'h00;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_ram();
    t_ctl();
    t_pm();
    t_info();
    t_data();
    end_sim();
  end
  // watchdog: whole run needs well under a microsecond per scenario
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule
